// [psmc_top.sv]
// Power saving mode control: slow-down, nap and deep sleep with pin state handling
//
// Summary of operation
// - Slow-down divides every oscillator-derived clock by eight, CPU and peripherals alike.
// - Setting slow_clock_select starts slow-down within two machine cycles.
// - Clearing slow_clock_select restores the nominal rate.
// - Interrupt wake from nap resumes CPU; slow-down stays until software clears it.
// - A two machine cycle reset fully resets out of nap with slow-down.
// - Deep sleep stops both oscillators; RAM and registers keep contents.
// - In deep sleep latch pins drive latches, alternate pins hold last values.
// - In deep sleep address latch strobe and program fetch strobe are low.
// - Only hardware reset leaves deep sleep, restoring register reset values.
// - Arm and trigger in one write never enter deep sleep.
// - Arm and trigger bits self-clear and always read as zero.
// - The trigger write is the last instruction before deep sleep.
// - Reset restarts both oscillators and waits for them to settle.
// - Permit pin high forces the deep trigger to zero.
// - Nap and deep requested together enter deep sleep.
`timescale 1ns/1ps
module psmc_top
  import psmc_pkg::*;
#(
  parameter int unsigned PORT_W = 8,
  parameter int unsigned SETTLE_CYC = PSMC_SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic powersave_permit_pin_i,
  input wire logic wake_i,
  input wire psmc_strobe_t core_strobe_i,
  input wire logic [PORT_W-1:0] port_latch_i,
  input wire logic [PORT_W-1:0] alt_out_i,
  input wire logic [PORT_W-1:0] alt_sel_i,
  output psmc_strobe_t strobe_o,
  output logic [PORT_W-1:0] port_o,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic osc_run_o
);

  localparam int unsigned SW = $clog2(SETTLE_CYC + 1);
  localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and oscillator settling

  logic permit_meta_q;
  logic permit_q;
  logic [SW-1:0] settle_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      permit_meta_q <= 1'b1;
      permit_q <= 1'b1;
    end else begin
      permit_meta_q <= powersave_permit_pin_i;
      permit_q <= permit_meta_q;
    end
  end

  // Core clocks stay off until the restarted oscillator has had time to settle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settle_q <= '0;
    end else if (settle_q != SETTLE_LAST) begin
      settle_q <= settle_q + SW'(1);
    end
  end

  wire logic settled = (settle_q == SETTLE_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  logic ack_q;
  psmc_pwrctl_t pwrctl_q;
  logic nap_arm_q;
  logic deep_arm_q;
  psmc_mode_t mode_q;
  psmc_mode_t mode_d;
  logic slow_act;

  wire logic req = wb_cyc_i && wb_stb_i;
  wire logic hit_pwrctl = (wb_adr_i == PSMC_PWRCTL_ADR);
  wire logic hit_stat = (wb_adr_i == PSMC_STAT_ADR);
  // Write commits at the edge where the master sees ack
  wire logic wr_fire = req && wb_we_i && ack_q && wb_sel_i[0];
  wire logic pw_fire = wr_fire && hit_pwrctl && (mode_q != PSMC_DEEP);
  wire psmc_pwrctl_t wd = psmc_pwrctl_t'(wb_dat_i[7:0]);

  // Arm and trigger bits are never stored in pwrctl_q, so they read back as zero
  wire psmc_pwrctl_t pwrctl_rd = '{spare: pwrctl_q.spare, deep_sleep_trigger: 1'b0, nap_trigger: 1'b0,
                                slow_clock_select: pwrctl_q.slow_clock_select, gen_flag1: pwrctl_q.gen_flag1,
                                gen_flag0: pwrctl_q.gen_flag0, deep_sleep_arm: 1'b0, nap_arm: 1'b0};
  wire logic [7:0] stat_rd = {3'h0, permit_q, slow_act, mode_q};
  wire logic [31:0] rd_mux = hit_pwrctl ? {24'h0, pwrctl_rd} : (hit_stat ? {24'h0, stat_rd} : 32'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack_q <= req && !ack_q;
      wb_dat_o <= (req && !ack_q) ? rd_mux : 32'h0;
    end
  end

  assign wb_ack_o = ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // power_control_reg and entry sequences

  // An arm survives only until the next write to the register
  wire logic deep_arm_d = wd.deep_sleep_arm && !wd.deep_sleep_trigger;
  wire logic nap_arm_d = wd.nap_arm && !wd.nap_trigger;
  wire logic go_deep = pw_fire && deep_arm_q && wd.deep_sleep_trigger && !wd.deep_sleep_arm
                       && !permit_q;
  wire logic go_nap = pw_fire && nap_arm_q && wd.nap_trigger && !wd.nap_arm;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwrctl_q <= psmc_pwrctl_t'(PSMC_PWRCTL_RST);
      nap_arm_q <= 1'b0;
      deep_arm_q <= 1'b0;
    end else if (pw_fire) begin
      pwrctl_q <= pwrctl_rd;
      pwrctl_q.spare <= wd.spare;
      pwrctl_q.slow_clock_select <= wd.slow_clock_select;
      pwrctl_q.gen_flag1 <= wd.gen_flag1;
      pwrctl_q.gen_flag0 <= wd.gen_flag0;
      nap_arm_q <= nap_arm_d;
      deep_arm_q <= deep_arm_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      PSMC_RUN: begin
        if (go_deep) begin
          mode_d = PSMC_DEEP;
        end else if (go_nap) begin
          mode_d = PSMC_NAP;
        end
      end
      PSMC_NAP: begin
        if (wake_i) begin
          mode_d = PSMC_RUN;
        end
      end
      PSMC_DEEP: begin
        mode_d = PSMC_DEEP;
      end
      default: begin
        mode_d = PSMC_RUN;
      end
    endcase
  end

  // Synchronous reset leaves nap or deep sleep at once; the clock never stops here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= PSMC_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock enables

  logic tick;

  psmc_clkdiv #(
    .DIV(PSMC_SLOW_DIV),
    .MC(PSMC_OSC_PER_MC)
  ) u_clkdiv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(settled),
    .slow_req_i(pwrctl_q.slow_clock_select),
    .tick_o(tick),
    .mcycle_o(),
    .slow_o(slow_act)
  );

  // Using the next mode keeps any instruction from running after the trigger write
  wire logic cpu_en_d = tick && (mode_d == PSMC_RUN);
  wire logic per_en_d = tick && (mode_d != PSMC_DEEP);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_clk_en_o <= 1'b0;
      periph_clk_en_o <= 1'b0;
      osc_run_o <= 1'b1;
    end else begin
      cpu_clk_en_o <= cpu_en_d;
      periph_clk_en_o <= per_en_d;
      osc_run_o <= (mode_d != PSMC_DEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin states

  logic [PORT_W-1:0] alt_hold_q;
  logic [PORT_W-1:0] port_d;
  wire logic deep = (mode_q == PSMC_DEEP);

  for (genvar i = 0; i < PORT_W; i++) begin : g_pin
    // Last alternate value before entry stays frozen while in deep sleep
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        alt_hold_q[i] <= 1'b0;
      end else if (!deep) begin
        alt_hold_q[i] <= alt_out_i[i];
      end
    end
    assign port_d[i] = alt_sel_i[i] ? (deep ? alt_hold_q[i] : alt_out_i[i]) : port_latch_i[i];
  end

  wire psmc_strobe_t strobe_d = deep ? psmc_strobe_t'(2'h0) :
                                ((mode_q == PSMC_NAP) ? psmc_strobe_t'(2'h3) : core_strobe_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_o <= '{1'b1, 1'b1};
      port_o <= '0;
    end else begin
      strobe_o <= strobe_d;
      port_o <= port_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  same_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pw_fire && wd.deep_sleep_arm && wd.deep_sleep_trigger && mode_q == PSMC_RUN |=> mode_q != PSMC_DEEP)
    else $error("deep sleep entered from combined write");

  deep_strobe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_q == PSMC_DEEP |=> !strobe_o.addr_latch_strobe && !strobe_o.program_fetch_strobe)
    else $error("strobes not low in deep sleep");

  deep_stay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_q == PSMC_DEEP |=> mode_q == PSMC_DEEP) else $error("deep sleep left without reset");

  permit_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    permit_q && mode_q != PSMC_DEEP |=> mode_q != PSMC_DEEP) else $error("deep sleep entered while blocked");

  trig_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && hit_pwrctl && !wb_we_i |-> wb_dat_o[PSMC_DEEP_TRIG_BIT] == 1'b0 && wb_dat_o[PSMC_DEEP_ARM_BIT] == 1'b0
      && wb_dat_o[PSMC_NAP_TRIG_BIT] == 1'b0 && wb_dat_o[PSMC_NAP_ARM_BIT] == 1'b0)
    else $error("arm or trigger bit read as one");

  deep_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    go_deep |=> (!osc_run_o && !cpu_clk_en_o && !periph_clk_en_o) [*3]) else $error("clocks run in deep sleep");

  nap_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_q == PSMC_NAP && wake_i |=> mode_q == PSMC_RUN && $stable(pwrctl_q.slow_clock_select))
    else $error("wake did not resume or changed slow-down");

  deep_prio_a: assert property (@(posedge clk_i) disable iff (rst_i)
    go_deep && go_nap && mode_q == PSMC_RUN |=> mode_q == PSMC_DEEP) else $error("nap won over deep sleep");

  alt_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_q == PSMC_DEEP ##1 mode_q == PSMC_DEEP |-> $stable(alt_hold_q)) else $error("held pin value moved");

endmodule // psmc_top

// [psmc_pkg.sv]
// Constants, field layouts and state codes shared by the power saving mode control block
package psmc_pkg;

  // Register map: word index times four gives the byte address
  localparam logic [7:0] PSMC_PWRCTL_IDX = 8'h87;
  localparam logic [7:0] PSMC_STAT_IDX = 8'h88;
  localparam logic [11:0] PSMC_PWRCTL_ADR = {2'h0, PSMC_PWRCTL_IDX, 2'h0};
  localparam logic [11:0] PSMC_STAT_ADR = {2'h0, PSMC_STAT_IDX, 2'h0};
  localparam logic [7:0] PSMC_PWRCTL_RST = 8'h00;

  // Bit positions of power_control_reg
  localparam int unsigned PSMC_NAP_ARM_BIT = 0;
  localparam int unsigned PSMC_DEEP_ARM_BIT = 1;
  localparam int unsigned PSMC_NAP_TRIG_BIT = 5;
  localparam int unsigned PSMC_DEEP_TRIG_BIT = 6;

  // Clocking figures
  localparam int unsigned PSMC_SLOW_DIV = 8;
  localparam int unsigned PSMC_OSC_PER_MC = 12;
  localparam int unsigned PSMC_SETTLE_CYC = 16;

  typedef struct packed {
    logic spare;
    logic deep_sleep_trigger;
    logic nap_trigger;
    logic slow_clock_select;
    logic gen_flag1;
    logic gen_flag0;
    logic deep_sleep_arm;
    logic nap_arm;
  } psmc_pwrctl_t;

  typedef struct packed {
    logic addr_latch_strobe;
    logic program_fetch_strobe;
  } psmc_strobe_t;

  typedef enum logic [2:0] {
    PSMC_RUN  = 3'b001,
    PSMC_NAP  = 3'b010,
    PSMC_DEEP = 3'b100
  } psmc_mode_t;

endpackage

// [psmc_clkdiv.sv]
// Oscillator tick generator with divide-by-eight slow-down switched at machine-cycle boundaries
`timescale 1ns/1ps
module psmc_clkdiv
  import psmc_pkg::*;
#(
  parameter int unsigned DIV = PSMC_SLOW_DIV,
  parameter int unsigned MC = PSMC_OSC_PER_MC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic slow_req_i,
  output logic tick_o,
  output logic mcycle_o,
  output logic slow_o
);

  localparam int unsigned PW = $clog2(DIV);
  localparam int unsigned CW = $clog2(MC);
  localparam logic [PW-1:0] PRE_LAST = PW'(DIV - 1);
  localparam logic [CW-1:0] PH_LAST = CW'(MC - 1);

  logic [PW-1:0] pre_q;
  logic [CW-1:0] phase_q;
  logic slow_q;

  wire logic pre_wrap = (pre_q == PRE_LAST);
  wire logic tick = run_i && (!slow_q || pre_wrap);
  wire logic boundary = tick && (phase_q == PH_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i || !slow_q || !run_i) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_wrap ? '0 : pre_q + PW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= '0;
    end else if (tick) begin
      phase_q <= (phase_q == PH_LAST) ? '0 : phase_q + CW'(1);
    end
  end

  // Rate only changes on a machine-cycle edge, so no clipped pulse reaches the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_q <= 1'b0;
    end else if (boundary) begin
      slow_q <= slow_req_i;
    end
  end

  assign tick_o = tick;
  assign mcycle_o = boundary;
  assign slow_o = slow_q;

  slow_div_a: assert property (@(posedge clk_i) disable iff (rst_i)
    slow_q && tick && !(boundary && !slow_req_i) |=> !tick [*7]) else $error("slow tick spacing not eight");

  slow_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(slow_req_i) && run_i && !slow_q |-> ##[1:24] slow_q) else $error("slow-down not entered in time");

  slow_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(slow_req_i) && run_i && slow_q |-> ##[1:96] !slow_q) else $error("slow-down not left in time");

  rate_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(slow_q) |-> $past(boundary)) else $error("rate switched inside machine cycle");

endmodule // psmc_clkdiv

// [tb_psmc_top.sv]
// Self-checking testbench for the power saving mode control block
`timescale 1ns/1ps
module tb_psmc_top
  import psmc_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [11:0] wb_adr = 12'h000;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic permit = 1'b0;
  logic wake = 1'b0;
  psmc_strobe_t core_strobe = 2'h2;
  logic [7:0] latch = 8'h3c;
  logic [7:0] alt_out = 8'ha5;
  logic [7:0] alt_sel = 8'hf0;
  psmc_strobe_t strobe;
  logic [7:0] port;
  logic cpu_en;
  logic per_en;
  logic osc_run;
  int fail_count = 0;
  int checks = 0;
  int c;
  int p;
  ////////////////////////////////////////////////////////////////////////
  // Short settle count keeps the run brief
  psmc_top #(.PORT_W(8), .SETTLE_CYC(2)) psmc_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .powersave_permit_pin_i(permit), .wake_i(wake), .core_strobe_i(core_strobe),
    .port_latch_i(latch), .alt_out_i(alt_out), .alt_sel_i(alt_sel), .strobe_o(strobe),
    .port_o(port), .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en), .osc_run_o(osc_run)
  );
  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single cycle; request held until ack is sampled high
  task automatic wb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_rdat;
    if (n >= 50) chk("ack", 32'h1, 32'h0);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, {24'h0, d}, q);
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb_xfer(1'b0, a, 32'h0, q);
    chk(nm, {24'h0, e}, q);
  endtask

  task automatic cnt(input int n);
    c = 0;
    p = 0;
    repeat (n) begin
      @(posedge clk_i);
      c += (cpu_en === 1'b1) ? 1 : 0;
      p += (per_en === 1'b1) ? 1 : 0;
    end
  endtask

  task automatic do_reset(input int n);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("osc run", 32'h1, osc_run);
    chk("strobe run", 32'h2, strobe);
    rd("pwrctl reset", PSMC_PWRCTL_ADR, 8'h00);
    rd("status reset", PSMC_STAT_ADR, 8'h01);
    rd("unmapped", 12'h100, 8'h00);
    wr(PSMC_PWRCTL_ADR, 8'h8f);
    rd("arm bits read 0", PSMC_PWRCTL_ADR, 8'h8c);
    wr(PSMC_PWRCTL_ADR, 8'h00);
    $display("test registers done");

    cnt(24);
    chk("cpu nominal", 32'h18, c);
    wr(PSMC_PWRCTL_ADR, 8'h10);
    repeat (24) @(posedge clk_i);
    cnt(96);
    chk("cpu slow", 32'h0c, c);
    chk("periph slow", 32'h0c, p);
    rd("status slow", PSMC_STAT_ADR, 8'h09);
    wr(PSMC_PWRCTL_ADR, 8'h00);
    repeat (100) @(posedge clk_i);
    cnt(24);
    chk("cpu back", 32'h18, c);
    chk("periph back", 32'h18, p);
    $display("test slow down done");

    wr(PSMC_PWRCTL_ADR, 8'h42);
    repeat (3) @(posedge clk_i);
    rd("status same write", PSMC_STAT_ADR, 8'h01);
    @(posedge clk_i);
    permit <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr(PSMC_PWRCTL_ADR, 8'h02);
    wr(PSMC_PWRCTL_ADR, 8'h40);
    repeat (3) @(posedge clk_i);
    rd("status permit high", PSMC_STAT_ADR, 8'h11);
    @(posedge clk_i);
    permit <= 1'b0;
    repeat (4) @(posedge clk_i);
    $display("test refused entry done");

    wr(PSMC_PWRCTL_ADR, 8'h01);
    wr(PSMC_PWRCTL_ADR, 8'h30);
    // Slow-down may need up to two machine cycles to engage
    repeat (24) @(posedge clk_i);
    rd("status nap", PSMC_STAT_ADR, 8'h0a);
    cnt(24);
    chk("cpu nap", 32'h0, c);
    chk("periph nap", 32'h3, p);
    chk("strobe nap", 32'h3, strobe);
    @(posedge clk_i);
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd("status woken", PSMC_STAT_ADR, 8'h09);
    rd("slow kept", PSMC_PWRCTL_ADR, 8'h10);
    // Arm write keeps slow select set, as an or-write from the core would
    wr(PSMC_PWRCTL_ADR, 8'h11);
    wr(PSMC_PWRCTL_ADR, 8'h30);
    repeat (3) @(posedge clk_i);
    rd("status nap again", PSMC_STAT_ADR, 8'h0a);
    do_reset(24);
    rd("status nap reset", PSMC_STAT_ADR, 8'h01);
    rd("pwrctl nap reset", PSMC_PWRCTL_ADR, 8'h00);
    $display("test nap done");

    wr(PSMC_PWRCTL_ADR, 8'h03);
    wr(PSMC_PWRCTL_ADR, 8'h60);
    repeat (3) @(posedge clk_i);
    rd("status both", PSMC_STAT_ADR, 8'h04);
    do_reset(4);
    $display("test precedence done");

    chk("port run", 32'hac, port);
    wr(PSMC_PWRCTL_ADR, 8'h0c);
    // No conversion runs in this bench, so the entry sequence may start at once
    wr(PSMC_PWRCTL_ADR, 8'h0e);
    wr(PSMC_PWRCTL_ADR, 8'h4c);
    cnt(2);
    chk("cpu after trigger", 32'h0, c);
    repeat (2) @(posedge clk_i);
    alt_out <= 8'h5a;
    latch <= 8'h99;
    repeat (3) @(posedge clk_i);
    chk("osc deep", 32'h0, osc_run);
    chk("strobe deep", 32'h0, strobe);
    chk("port deep", 32'ha9, port);
    cnt(16);
    chk("cpu deep", 32'h0, c);
    chk("periph deep", 32'h0, p);
    rd("pwrctl kept", PSMC_PWRCTL_ADR, 8'h0c);
    wr(PSMC_PWRCTL_ADR, 8'h10);
    rd("pwrctl write ignored", PSMC_PWRCTL_ADR, 8'h0c);
    @(posedge clk_i);
    wake <= 1'b1;
    repeat (4) @(posedge clk_i);
    wake <= 1'b0;
    rd("status stays deep", PSMC_STAT_ADR, 8'h04);
    do_reset(4);
    chk("osc restart", 32'h1, osc_run);
    rd("pwrctl after deep", PSMC_PWRCTL_ADR, 8'h00);
    rd("status after deep", PSMC_STAT_ADR, 8'h01);
    cnt(8);
    chk("cpu restart", 32'h8, c);
    $display("test deep sleep done");
    test_done();
  end

  // Whole run needs about five hundred and forty cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    $display("mismatch watchdog expected done seen hang");
    test_done();
  end
endmodule // tb_psmc_top
